// File: pch_config_header.sv
// module: config header slice of a serial bus host-controller function
`timescale 1ns/1ps
module pch_config_header
  import pch_pkg::*;
#(
  parameter logic [7:0] SILICON_REVISION = 8'h5a // arbitrary value
)
(
  input  wire logic        CLK,
  input  wire logic        NRST,
  input  wire logic        CE,
  input  wire logic        CFG_WR,
  input  wire logic        CFG_RD,
  input  wire logic [7:0]  CFG_ADDR,
  input  wire logic [3:0]  CFG_BE,
  input  wire logic [31:0] CFG_WDATA,
  output logic      [31:0] CFG_RDATA,
  input  wire logic        MEM_CYCLE,
  input  wire logic [31:0] MEM_ADDR,
  output logic             MEM_HIT,
  input  wire logic        FRAME_START,
  input  wire logic        XFER_ACTIVE,
  input  wire logic        GNT_N,
  input  wire logic [1:0]  MEM_CMD_KIND,
  output logic             TERMINATE,
  output logic      [7:0]  LINE_LENGTH,
  output logic             LINE_LENGTH_VALID
);
  logic        rst_sync1;
  logic        rst_n;
  logic [7:0]  latency_limit;
  logic [7:0]  system_line_length;
  logic [20:0] host_window_pointer;
  logic        memory_response_enable;
  logic [31:0] next_rdata;
  pch_lat_if   lat ();
  logic        wr_lat_line;
  logic        wr_window;
  logic        wr_command;

  // merge one byte lane when its enable is set
  function automatic logic [7:0] lane(input logic [7:0] old_v,
                                      input logic [7:0] new_v,
                                      input logic       en);
    lane = en ? new_v : old_v;
  endfunction : lane

  // config write decode, shared by every writable register
  function automatic logic wr_sel(input logic       ce_v,
                                  input logic       wr_v,
                                  input logic [7:0] addr_v,
                                  input logic [7:0] ofs);
    wr_sel = ce_v && wr_v && addr_v == ofs;
  endfunction : wr_sel

  // pointer and wired low bits must tile the 32-bit base word exactly
  if (WINDOW_PTR_LSB + $bits(host_window_pointer) != 32)
  begin : g_window_geometry
    $error("window pointer and low bits do not tile the base word");
  end

  // write decode per register; reads need no decode beyond the mux
  // CE folded in here, so a frozen clock also drops config writes
  assign wr_lat_line = wr_sel(CE, CFG_WR, CFG_ADDR,
                              OFS_LATENCY_AND_CACHE_LINE);
  assign wr_window   = wr_sel(CE, CFG_WR, CFG_ADDR,
                              OFS_HOST_CTRL_WINDOW_BASE);
  assign wr_command  = wr_sel(CE, CFG_WR, CFG_ADDR, OFS_COMMAND);

  // reset release through two flops; assert stays asynchronous
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      rst_sync1 <= 1'b0;
      rst_n     <= 1'b0;
    end
    else
    begin
      rst_sync1 <= 1'b1;
      rst_n     <= rst_sync1;
    end
  end

  // latency and line length; upper lanes at 0Ch are read-only
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      system_line_length <= LAT_CACHE_RESET[7:0];
      latency_limit      <= LAT_CACHE_RESET[15:8];
    end
    else if (wr_lat_line)
    begin
      system_line_length <= lane(system_line_length, CFG_WDATA[7:0],
                                 CFG_BE[0]);
      latency_limit      <= lane(latency_limit, CFG_WDATA[15:8],
                                 CFG_BE[1]);
      // lanes 2-3 map header kind and self test, dropped here
    end
  end

  // window pointer: only bits 31-11 store, lower bits are wired
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
      host_window_pointer <= WINDOW_PTR_RESET;
    else if (wr_window)
    begin
      host_window_pointer[20:13] <= lane(host_window_pointer[20:13],
                                         CFG_WDATA[31:24], CFG_BE[3]);
      host_window_pointer[12:5]  <= lane(host_window_pointer[12:5],
                                         CFG_WDATA[23:16], CFG_BE[2]);
      if (CFG_BE[1])
        host_window_pointer[4:0] <= CFG_WDATA[15:11];
    end
  end

  // memory response enable, the one command bit this slice keeps
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
      memory_response_enable <= 1'b0;
    else if (wr_command && CFG_BE[0])
      memory_response_enable <= CFG_WDATA[MEM_ENABLE_BIT];
  end

  // read mux; unmapped offsets read zero, class word is constant
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    unique case (CFG_ADDR)
      OFS_CLASS_CODE_AND_REVISION:
        next_rdata = {FUNCTION_CATEGORY, SERIAL_SUBCLASS,
                      PROGRAMMING_MODEL_CODE,
                      SILICON_REVISION};
      OFS_LATENCY_AND_CACHE_LINE:
        next_rdata = {SELF_TEST_BYTE, HEADER_KIND, latency_limit,
                      system_line_length};
      OFS_HEADER_KIND_SELF_TEST:
        next_rdata = {16'h0000, SELF_TEST_BYTE, HEADER_KIND};
      OFS_HOST_CTRL_WINDOW_BASE:
        next_rdata = {host_window_pointer, WINDOW_SIZE_BITS,
                      WINDOW_LOW_FLAGS};
      OFS_COMMAND:
        next_rdata = {30'h0, memory_response_enable, 1'b0};
      default:
        next_rdata = 32'h0000_0000;
    endcase
  end

  // registered read data, captured on a read strobe
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
      CFG_RDATA <= 32'h0000_0000;
    else if (CE && CFG_RD)
      CFG_RDATA <= next_rdata;
  end

  // window decode: 2K region, gated by the enable
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
      MEM_HIT <= 1'b0;
    else if (CE)
      MEM_HIT <= MEM_CYCLE && memory_response_enable &&
                 MEM_ADDR[31:WINDOW_PTR_LSB] == host_window_pointer;
  end

  // latency counter wiring
  assign lat.ce          = CE;
  assign lat.limit       = latency_limit;
  assign lat.frame_start = FRAME_START;
  assign lat.xfer_active = XFER_ACTIVE;

  pch_latency_counter u_lat (
    .clk   (CLK),
    .rst_n (rst_n),
    .lat   (lat)
  );

  // terminate only once grant is gone after expiry, not on expiry alone
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
      TERMINATE <= 1'b0;
    else if (CE)
      TERMINATE <= XFER_ACTIVE && lat.expired && GNT_N;
  end

  // line length offered for line, multiple and invalidate commands
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      LINE_LENGTH       <= 8'h00;
      LINE_LENGTH_VALID <= 1'b0;
    end
    else if (CE)
    begin
      LINE_LENGTH       <= system_line_length;
      LINE_LENGTH_VALID <= MEM_CMD_KIND != 2'b00;
    end
  end
endmodule : pch_config_header

// File: pch_pkg.sv
// package: offsets, field layout and reset values for config header
package pch_pkg;
  localparam logic [7:0]  OFS_CLASS_CODE_AND_REVISION = 8'h08;
  localparam logic [7:0]  OFS_LATENCY_AND_CACHE_LINE  = 8'h0c;
  localparam logic [7:0]  OFS_HEADER_KIND_SELF_TEST   = 8'h0e;
  localparam logic [7:0]  OFS_HOST_CTRL_WINDOW_BASE   = 8'h10;
  localparam logic [7:0]  OFS_COMMAND                 = 8'h04;
  localparam logic [7:0]  FUNCTION_CATEGORY           = 8'h0c;
  localparam logic [7:0]  SERIAL_SUBCLASS             = 8'h00;
  localparam logic [7:0]  PROGRAMMING_MODEL_CODE      = 8'h10;
  localparam logic [7:0]  SELF_TEST_BYTE              = 8'h00;
  localparam logic [7:0]  HEADER_KIND                 = 8'h00;
  localparam logic [15:0] LAT_CACHE_RESET             = 16'h0000;
  localparam logic [20:0] WINDOW_PTR_RESET            = 21'h0;
  localparam int          WINDOW_PTR_LSB              = 11;
  localparam int          MEM_ENABLE_BIT              = 1;
  localparam logic [3:0]  WINDOW_LOW_FLAGS            = 4'h0;
  localparam logic [6:0]  WINDOW_SIZE_BITS            = 7'h00;
endpackage : pch_pkg

// File: pch_lat_if.sv
// interface: latency counter control and status between config and counter
`timescale 1ns/1ps
interface pch_lat_if;
  logic       ce;
  logic [7:0] limit;
  logic       frame_start;
  logic       xfer_active;
  logic       expired;
  modport cfg (output ce, output limit, output frame_start,
               output xfer_active, input expired);
  modport cnt (input ce, input limit, input frame_start,
               input xfer_active, output expired);
endinterface : pch_lat_if

// File: pch_latency_counter.sv
// module: initiator latency counter in bus clock cycles
`timescale 1ns/1ps
module pch_latency_counter
  import pch_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  pch_lat_if.cnt    lat
);
  logic [7:0] count;

  // restart from zero at frame assertion, stop at the programmed value
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      count <= 8'h00;
    else if (lat.ce)
    begin
      if (lat.frame_start)
        count <= 8'h00;
      else if (lat.xfer_active && count != lat.limit)
        count <= count + 8'h01;
    end
  end

  // expiry sticks until the next frame begins
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      lat.expired <= 1'b0;
    else if (lat.ce)
    begin
      if (lat.frame_start)
        lat.expired <= 1'b0;
      else if (lat.xfer_active && count == lat.limit)
        lat.expired <= 1'b1;
    end
  end
endmodule : pch_latency_counter

// File: pch_monitor.sv
// checker: port assertions for the config header
`timescale 1ns/1ps
module pch_monitor
  import pch_pkg::*;
#(parameter logic [7:0] SILICON_REVISION = 8'h5a)
(
  input wire logic        CLK, NRST, CE, CFG_WR, CFG_RD,
  input wire logic        MEM_CYCLE, MEM_HIT, XFER_ACTIVE, GNT_N,
  input wire logic        TERMINATE, LINE_LENGTH_VALID,
  input wire logic [7:0]  CFG_ADDR,
  input wire logic [3:0]  CFG_BE,
  input wire logic [1:0]  MEM_CMD_KIND,
  input wire logic [31:0] CFG_WDATA, CFG_RDATA
);
  logic mem_en;
  // shadow of memory enable, so hits can be tied to their cause
  always_ff @(posedge CLK or negedge NRST)
    if (!NRST)
      mem_en <= 1'b0;
    else if (CE && CFG_WR && CFG_ADDR == 8'h04 && CFG_BE[0])
      mem_en <= CFG_WDATA[1];
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  sequence rd(a);
    CE && CFG_RD && CFG_ADDR == a;
  endsequence
  AST_BASE: assert property (rd(8'h08) |=> CFG_RDATA[31:24]==8'h0c)
    else $error("base class byte wrong");
  AST_SUB: assert property (
    rd(8'h08) |=> CFG_RDATA[23:16] == SERIAL_SUBCLASS)
    else $error("subclass byte wrong");
  AST_PGM: assert property (rd(8'h08) |=> CFG_RDATA[15:8]==8'h10)
    else $error("programming model byte wrong");
  AST_REV: assert property (
    rd(8'h08) |=> CFG_RDATA[7:0] == SILICON_REVISION)
    else $error("revision byte wrong");
  AST_TOP: assert property (
    rd(8'h0c) |=> CFG_RDATA[31:16] == 16'h0000)
    else $error("header or self-test byte wrong");
  AST_LOW: assert property (
    rd(8'h10) |=> CFG_RDATA[10:0] == 11'h000)
    else $error("base low bits not zero");
  AST_HIT: assert property (
    MEM_HIT && $past(CE) |-> $past(MEM_CYCLE && mem_en))
    else $error("window hit without enable");
  AST_TERM: assert property (
    TERMINATE && $past(CE) |-> $past(XFER_ACTIVE && GNT_N))
    else $error("terminate with grant");
  AST_LINE: assert property (
    LINE_LENGTH_VALID && $past(CE) |-> $past(MEM_CMD_KIND) != 2'b00)
    else $error("line size on other cmd");
  cover property (MEM_HIT);
  cover property (TERMINATE);
  cover property (LINE_LENGTH_VALID);
endmodule : pch_monitor
bind pch_config_header pch_monitor
  #(.SILICON_REVISION(SILICON_REVISION)) mon (.*);

// File: pch_host_model.sv
// partner: host bridge issuing configuration cycles
`timescale 1ns/1ps
module pch_host_model (
  input  wire logic        clk,
  input  wire logic [31:0] rdata,
  output logic             wr,
  output logic             rd,
  output logic      [7:0]  addr,
  output logic      [3:0]  be,
  output logic      [31:0] wdata
);
  initial
    {wr, rd, addr, be, wdata} = '0;
  // one strobe edge; data flipped once released, never left stale
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [3:0] b, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk);
    {wr, rd, addr, be, wdata} <= {w, !w, a, b, d};
    @(posedge clk);
    {wr, rd, wdata} <= {2'b00, ~d};
    @(posedge clk);
    q = rdata;
  endtask : xfer
endmodule : pch_host_model

// File: tb_top.sv
// testbench: config header scenarios
`timescale 1ns/1ps
module tb_top;
  localparam logic [7:0] REV = 8'h3c; // arbitrary value
  logic        clk = 0, nrst = 0, ce = 1, mc = 0, fs = 0, xa = 0;
  logic        gnt_n = 0, wr, rd, hit, term, llv;
  logic [1:0]  kind = '0;
  logic [3:0]  be;
  logic [7:0]  addr, ll;
  logic [31:0] wd, rdata, q, ma = '0;
  int          error_cnt = 0, total_checks = 0;
  always #10 clk = ~clk;
  pch_config_header #(.SILICON_REVISION(REV)) uut (
    .CLK(clk), .NRST(nrst), .CE(ce), .CFG_WR(wr), .CFG_RD(rd),
    .CFG_ADDR(addr), .CFG_BE(be), .CFG_WDATA(wd), .CFG_RDATA(rdata),
    .MEM_CYCLE(mc), .MEM_ADDR(ma), .MEM_HIT(hit), .FRAME_START(fs),
    .XFER_ACTIVE(xa), .GNT_N(gnt_n), .MEM_CMD_KIND(kind),
    .TERMINATE(term), .LINE_LENGTH(ll), .LINE_LENGTH_VALID(llv));
  pch_host_model host (.clk(clk), .rdata(rdata), .wr(wr), .rd(rd),
    .addr(addr), .be(be), .wdata(wd));
  task chk(input string n, input logic [31:0] s, e);
    total_checks++;
    if (s !== e)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task cw(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    host.xfer(1'b1, a, b, d, q);
  endtask : cw
  task cr(input logic [7:0] a);
    host.xfer(1'b0, a, 4'hf, '0, q);
  endtask : cr
  task tk(input int n);
    repeat (n) @(posedge clk);
  endtask : tk
  task t_id;
    cr(8'h08);
    chk("class", q, {24'h0c0010, REV});
    cr(8'h0c);
    chk("lat_hdr", q, '0);
    cr(8'h10);
    chk("base", q, '0);
    cw(8'h08, 4'hf, '1);
    cw(8'h0c, 4'hc, '1);
    cr(8'h08);
    chk("class_ro", q, {24'h0c0010, REV});
    cr(8'h0c);
    chk("hdr_ro", q, '0);
    cw(8'h10, 4'hf, '1);
    cr(8'h10);
    chk("base_ones", q, 32'hfffff800);
    $display("t_id done");
  endtask : t_id
  task t_mem;
    cw(8'h10, 4'hf, 32'h80000000);
    mc <= 1;
    ma <= 32'h800007fc;
    tk(2);
    #1 chk("hit_off", hit, 0);
    cw(8'h04, 4'h1, 32'h2);
    tk(1);
    #1 chk("hit_on", hit, 1);
    tk(1);
    ma <= 32'h80000800;
    tk(2);
    #1 chk("hit_out", hit, 0);
    $display("t_mem done");
  endtask : t_mem
  task t_lat;
    cw(8'h0c, 4'h3, 32'h0340);
    cr(8'h0c);
    chk("lat_line", q, 32'h0340);
    fs <= 1;
    xa <= 1;
    tk(1);
    fs <= 0;
    tk(8);
    #1 chk("term_held", term, 0);
    tk(1);
    gnt_n <= 1;
    tk(2);
    #1 chk("term", term, 1);
    tk(1);
    xa <= 0;
    tk(2);
    fs <= 1;
    xa <= 1;
    tk(1);
    fs <= 0;
    tk(2);
    #1 chk("restart", term, 0);
    $display("t_lat done");
  endtask : t_lat
  task t_line;
    for (int k = 1; k < 4; k++)
    begin
      tk(1);
      kind <= k[1:0];
      tk(2);
      #1 chk("line", {llv, ll}, 9'h140);
    end
    tk(1);
    kind <= 2'b00;
    tk(2);
    #1 chk("line_off", llv, 0);
    $display("t_line done");
  endtask : t_line
  task t_ce;
    tk(1);
    ce <= 0;
    kind <= 2'b01;
    cw(8'h0c, 4'h3, 32'h0000);
    #1 chk("ce_llv", llv, 0);
    tk(1);
    ce <= 1;
    cr(8'h0c);
    chk("ce_lat", q, 32'h0340);
    chk("ce_llv_on", llv, 1);
    kind <= 2'b00;
    $display("t_ce done");
  endtask : t_ce
  task t_rst;
    tk(1);
    ma <= 32'h80000400;
    tk(2);
    #1 chk("hit_pre", hit, 1);
    tk(1);
    nrst <= 0;
    tk(2);
    nrst <= 1;
    #1 chk("hit_rst", hit, 0);
    tk(3);
    cr(8'h0c);
    chk("lat_rst", q, '0);
    cr(8'h10);
    chk("base_rst", q, '0);
    cr(8'h04);
    chk("cmd_rst", q, '0);
    $display("t_rst done");
  endtask : t_rst
  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim
  initial
  begin
    tk(10);
    nrst <= 1;
    tk(3);
    t_id;
    t_mem;
    t_lat;
    t_line;
    t_ce;
    t_rst;
    end_sim;
  end
  // watchdog against a hung sequence
  initial
  begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    end_sim;
  end
endmodule : tb_top
